// ===== common/dtcm_params.svh
// offsets, field positions and reset values of the dual timer block
`ifndef DTCM_PARAMS_SVH
`define DTCM_PARAMS_SVH
`define DTCM_OFS_RUN_OVF    12'h088
`define DTCM_OFS_MODE_SEL   12'h089
`define DTCM_OFS_AUX_MODE   12'h08f
`define DTCM_OFS_COUNT0     12'h08a
`define DTCM_OFS_COUNT1     12'h08b
`define DTCM_OFS_AUX_CTRL1  12'h0a2
`define DTCM_WORD_SCALE     4
`define DTCM_BIT_TR0        4
`define DTCM_BIT_TF0        5
`define DTCM_BIT_TR1        6
`define DTCM_BIT_TF1        7
`define DTCM_BIT_TIMER0_MODE_TOP_BIT       0
`define DTCM_BIT_TIMER1_MODE_TOP_BIT       4
`define DTCM_BIT_CS0        2
`define DTCM_BIT_CS1        6
`define DTCM_BIT_TIMER0_TOGGLE_ENABLE       0
`define DTCM_BIT_TIMER1_TOGGLE_ENABLE       1
`define DTCM_RUN_OVF_RST    8'h00
`define DTCM_MODE_SEL_RST   8'h00
`define DTCM_AUX_MODE_RST   8'h00
`define DTCM_PRESCALE_MASK  8'h1f
`define DTCM_PWM_ALL_HIGH   8'h00
`define DTCM_PWM_ALL_LOW    8'hff
`endif

// ===== common/dtcm_pkg.sv
// types shared by the dual timer block
package dtcm_pkg;
	typedef enum logic [2:0] {
		DTCM_M13   = 3'b000,
		DTCM_M16   = 3'b001,
		DTCM_M8AR  = 3'b010,
		DTCM_MSPL  = 3'b011,
		DTCM_MPWM  = 3'b110
	} dtcm_mode_t;
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dtcm_count_t;
endpackage

// ===== rtl/dtcm_top.sv
// two up-counting timer/counters with pwm and toggle outputs, apb slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "dtcm_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RL1: mode is three bits; top bit from aux mode register bit 0 or 4.
// RL2: mode 0 is an 8-bit count behind a divide-by-32 prescaler.
// RL3: mode 0 uses high byte plus low five bits of the low byte.
// RL4: rollover from all ones to zero sets the overflow flag.
// RL5: count pulses pass only while the run bit is one.
// RL6: setting the run bit leaves both count bytes untouched.
// RL7: mode 1 cascades full sixteen bits with no prescaler.
// RL8: mode 2 low byte reloads from high byte on overflow, sets flag.
// RL9: timer 1 in mode 3 stops as if its run bit were clear.
// RL10: timer 0 mode 3 low byte uses timer 0 source, run and flag.
// RL11: timer 0 mode 3 high byte counts clocks via timer 1 run and flag.
// RL12: with timer 0 in mode 3, timer 1 runs unless itself in mode 3.
// RL13: software must not use mode codes 100, 101 or 111.
// RL14: mode 110 is pwm with a 256 clock period, auto-reload style.
// RL15: high byte sets low phase; high phase is 256 minus it.
// RL16: high byte 00h forces pin high, ffh forces pin low.
// RL17: in pwm mode hardware sets and clears the flag; software may clear.
// RL18: flags at bits 5 and 7 set on overflow, cleared on vector or software.
// RL19: run bits are bits 4 and 6; lower four bits reserved.
// RL20: with toggle enabled, pin output inverts on every overflow.
// RL21: toggle output is high until the first overflow after enable.
// RL22: toggle output needs internal clock counting selected.
// RL23: timer operation counts once per peripheral clock while running.
// RL24: counter operation counts on a high then low pin sample.
// RL25: source select clear picks clock, set picks external pin.
// RL26: each overflow flag is presented as an interrupt request output.
module dtcm_top
	import dtcm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer0_pin_in,
	input  wire logic        timer1_pin_in,
	output logic             timer0_pin_out,
	output logic             timer1_pin_out,
	output logic             timer0_pin_oe_n,
	output logic             timer1_pin_oe_n,
	input  wire logic        timer0_vector_ack,
	input  wire logic        timer1_vector_ack,
	output logic             timer0_irq,
	output logic             timer1_irq
);

	logic [7:0]  run_ovf_r;
	logic [7:0]  mode_sel_r;
	logic [7:0]  aux_mode_r;
	logic [1:0]  aux_ctrl1_r;
	dtcm_count_t cnt0_r, cnt1_r;
	dtcm_count_t cnt0_nxt, cnt1_nxt;
	logic [1:0]  pin_d_r;
	logic [1:0]  tog_r;
	logic [1:0]  pwm_r;
	dtcm_mode_t  mode0, mode1;
	logic        wr_en, rd_en, addr_ok;
	logic [11:0] word_addr;
	logic        tick0, tick1, tick0h;
	logic        ovf0, ovf1, ovf0h;
	logic        set_tf0, set_tf1, clr_tf0, clr_tf1;
	logic        pwm_rise0, pwm_rise1;

	////////////////////////////////////////////////////////////////////////
	// mode decode and count sources
	assign mode0 = dtcm_mode_t'({aux_mode_r[`DTCM_BIT_TIMER0_MODE_TOP_BIT],
		mode_sel_r[1:0]}); // RL1
	assign mode1 = dtcm_mode_t'({aux_mode_r[`DTCM_BIT_TIMER1_MODE_TOP_BIT],
		mode_sel_r[5:4]}); // RL1

	// pin edge: high last sample, low now; clock select bit picks source
	assign tick0 = run_ovf_r[`DTCM_BIT_TR0] &
		(mode_sel_r[`DTCM_BIT_CS0] ? (pin_d_r[0] & ~timer0_pin_in)
		: 1'b1); // RL5 RL23 RL24 RL25 RL10
	// timer 1 stopped in its own mode 3
	assign tick1 = run_ovf_r[`DTCM_BIT_TR1] & (mode1 != DTCM_MSPL) &
		(mode_sel_r[`DTCM_BIT_CS1] ? (pin_d_r[1] & ~timer1_pin_in)
		: 1'b1); // RL5 RL9 RL12 RL24 RL25
	// split high byte: clock only, gated by timer 1 run bit
	assign tick0h = (mode0 == DTCM_MSPL) &
		run_ovf_r[`DTCM_BIT_TR1]; // RL11

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_d_r <= 2'b00;
		end else begin
			pin_d_r <= {timer1_pin_in, timer0_pin_in};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counting per mode
	always_comb begin
		cnt0_nxt = cnt0_r;
		ovf0     = 1'b0;
		ovf0h    = 1'b0;
		if (tick0) begin
			case (mode0)
			DTCM_M13: begin
				// upper three low bits are don't-care; kept at zero
				if (cnt0_r.lo[4:0] == 5'h1f) begin
					cnt0_nxt.lo = 8'h00;
					cnt0_nxt.hi = cnt0_r.hi + 8'h01;
					ovf0 = (cnt0_r.hi == 8'hff); // RL2 RL3 RL4
				end else begin
					cnt0_nxt.lo = {3'b000, cnt0_r.lo[4:0] + 5'h01};
				end
			end
			DTCM_M16: begin
				cnt0_nxt = cnt0_r + 16'h0001; // RL7
				ovf0 = (cnt0_r == 16'hffff); // RL4
			end
			DTCM_M8AR, DTCM_MPWM: begin
				if (cnt0_r.lo == 8'hff) begin
					// pwm wraps to zero so the period stays 256 clocks
					cnt0_nxt.lo = (mode0 == DTCM_MPWM) ? 8'h00 :
						cnt0_r.hi; // RL8 RL14
					ovf0 = 1'b1;
				end else begin
					cnt0_nxt.lo = cnt0_r.lo + 8'h01;
				end
			end
			DTCM_MSPL: begin
				cnt0_nxt.lo = cnt0_r.lo + 8'h01; // RL10
				ovf0 = (cnt0_r.lo == 8'hff);
			end
			default: begin
				cnt0_nxt = cnt0_r;
			end
			endcase
		end
		if (tick0h) begin
			cnt0_nxt.hi = cnt0_r.hi + 8'h01; // RL11
			ovf0h = (cnt0_r.hi == 8'hff);
		end
		if (wr_en && word_addr == `DTCM_OFS_COUNT0) begin
			cnt0_nxt = pwdata[15:0];
		end
	end

	always_comb begin
		cnt1_nxt = cnt1_r;
		ovf1     = 1'b0;
		if (tick1) begin
			case (mode1)
			DTCM_M13: begin
				if (cnt1_r.lo[4:0] == 5'h1f) begin
					cnt1_nxt.lo = 8'h00;
					cnt1_nxt.hi = cnt1_r.hi + 8'h01;
					ovf1 = (cnt1_r.hi == 8'hff); // RL2 RL3 RL4
				end else begin
					cnt1_nxt.lo = {3'b000, cnt1_r.lo[4:0] + 5'h01};
				end
			end
			DTCM_M16: begin
				cnt1_nxt = cnt1_r + 16'h0001; // RL7
				ovf1 = (cnt1_r == 16'hffff);
			end
			DTCM_M8AR, DTCM_MPWM: begin
				if (cnt1_r.lo == 8'hff) begin
					cnt1_nxt.lo = (mode1 == DTCM_MPWM) ? 8'h00 :
						cnt1_r.hi; // RL8 RL14
					ovf1 = 1'b1;
				end else begin
					cnt1_nxt.lo = cnt1_r.lo + 8'h01;
				end
			end
			default: begin
				cnt1_nxt = cnt1_r;
			end
			endcase
		end
		if (wr_en && word_addr == `DTCM_OFS_COUNT1) begin
			cnt1_nxt = pwdata[15:0];
		end
	end

	// run bit writes never touch the count bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt0_r <= '0;
			cnt1_r <= '0;
		end else begin
			cnt0_r <= cnt0_nxt; // RL6
			cnt1_r <= cnt1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pwm phase: low for hi clocks, high for 256 - hi clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_r <= 2'b00;
		end else begin
			if (tick0 && mode0 == DTCM_MPWM) begin
				pwm_r[0] <= (cnt0_nxt.lo >= cnt0_r.hi); // RL15
			end
			if (tick1 && mode1 == DTCM_MPWM) begin
				pwm_r[1] <= (cnt1_nxt.lo >= cnt1_r.hi); // RL15
			end
		end
	end
	assign pwm_rise0 = tick0 && mode0 == DTCM_MPWM && !pwm_r[0] &&
		(cnt0_nxt.lo >= cnt0_r.hi);
	assign pwm_rise1 = tick1 && mode1 == DTCM_MPWM && !pwm_r[1] &&
		(cnt1_nxt.lo >= cnt1_r.hi);

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign word_addr = {2'b00, paddr[11:2]};
	assign addr_ok = (paddr[1:0] == 2'b00) &&
		((word_addr == `DTCM_OFS_RUN_OVF) ||
		(word_addr == `DTCM_OFS_MODE_SEL) ||
		(word_addr == `DTCM_OFS_AUX_MODE) ||
		(word_addr == `DTCM_OFS_COUNT0) || (word_addr == `DTCM_OFS_COUNT1) ||
		(word_addr == `DTCM_OFS_AUX_CTRL1));
	assign wr_en = psel & penable & pwrite & addr_ok;
	assign rd_en = psel & ~penable & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sel_r  <= `DTCM_MODE_SEL_RST;
			aux_mode_r  <= `DTCM_AUX_MODE_RST;
			aux_ctrl1_r <= 2'b00;
		end else if (wr_en) begin
			if (word_addr == `DTCM_OFS_MODE_SEL) begin
				mode_sel_r <= pwdata[7:0] & 8'h77;
			end
			if (word_addr == `DTCM_OFS_AUX_MODE) begin
				aux_mode_r <= pwdata[7:0] & 8'h11; // RL1
			end
			if (word_addr == `DTCM_OFS_AUX_CTRL1) begin
				aux_ctrl1_r <= pwdata[1:0];
			end
		end
	end

	// flag sources: split mode steers timer 0 high byte to timer 1 flag
	assign set_tf0 = (mode0 == DTCM_MPWM) ? pwm_rise0 : ovf0; // RL4 RL17
	assign set_tf1 = ((mode0 == DTCM_MSPL) ? ovf0h : 1'b0) |
		((mode1 == DTCM_MPWM) ? pwm_rise1 : ovf1); // RL11 RL17
	assign clr_tf0 = timer0_vector_ack | ((mode0 == DTCM_MPWM) &&
		tick0 && (cnt0_nxt.lo < cnt0_r.hi)); // RL17 RL18
	assign clr_tf1 = timer1_vector_ack | ((mode1 == DTCM_MPWM) &&
		tick1 && (cnt1_nxt.lo < cnt1_r.hi)); // RL17 RL18

	// hardware set wins over any clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_ovf_r <= `DTCM_RUN_OVF_RST;
		end else begin
			if (wr_en && word_addr == `DTCM_OFS_RUN_OVF) begin
				run_ovf_r <= pwdata[7:0] & 8'hf0; // RL19
			end else begin
				if (clr_tf0) begin
					run_ovf_r[`DTCM_BIT_TF0] <= 1'b0;
				end
				if (clr_tf1) begin
					run_ovf_r[`DTCM_BIT_TF1] <= 1'b0;
				end
			end
			if (set_tf0) begin
				run_ovf_r[`DTCM_BIT_TF0] <= 1'b1; // RL18
			end
			if (set_tf1) begin
				run_ovf_r[`DTCM_BIT_TF1] <= 1'b1; // RL18
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (rd_en) begin
				case (addr_ok ? word_addr : 12'hfff)
				`DTCM_OFS_RUN_OVF:   prdata <= {24'h0, run_ovf_r};
				`DTCM_OFS_MODE_SEL:  prdata <= {24'h0, mode_sel_r};
				`DTCM_OFS_AUX_MODE:  prdata <= {24'h0, aux_mode_r};
				`DTCM_OFS_COUNT0:    prdata <= {16'h0, cnt0_r};
				`DTCM_OFS_COUNT1:    prdata <= {16'h0, cnt1_r};
				`DTCM_OFS_AUX_CTRL1: prdata <= {30'h0, aux_ctrl1_r};
				default:             prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin outputs: toggle starts high; pwm forced levels at 00h and ffh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_r <= 2'b11;
		end else begin
			if (!aux_ctrl1_r[`DTCM_BIT_TIMER0_TOGGLE_ENABLE]) begin
				tog_r[0] <= 1'b1; // RL21
			end else if (ovf0) begin
				tog_r[0] <= ~tog_r[0]; // RL20
			end
			if (!aux_ctrl1_r[`DTCM_BIT_TIMER1_TOGGLE_ENABLE]) begin
				tog_r[1] <= 1'b1; // RL21
			end else if (ovf1) begin
				tog_r[1] <= ~tog_r[1]; // RL20
			end
		end
	end

	// toggle only meaningful with clock counting; pin is an input otherwise, except in pwm mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer0_pin_out  <= 1'b1;
			timer1_pin_out  <= 1'b1;
			timer0_pin_oe_n <= 1'b1;
			timer1_pin_oe_n <= 1'b1;
			timer0_irq      <= 1'b0;
			timer1_irq      <= 1'b0;
		end else begin
			if (mode0 == DTCM_MPWM) begin
				timer0_pin_out <= (cnt0_r.hi == `DTCM_PWM_ALL_HIGH) ? 1'b1 :
					(cnt0_r.hi == `DTCM_PWM_ALL_LOW) ? 1'b0 : pwm_r[0]; // RL16
			end else begin
				timer0_pin_out <= tog_r[0];
			end
			if (mode1 == DTCM_MPWM) begin
				timer1_pin_out <= (cnt1_r.hi == `DTCM_PWM_ALL_HIGH) ? 1'b1 :
					(cnt1_r.hi == `DTCM_PWM_ALL_LOW) ? 1'b0 : pwm_r[1]; // RL16
			end else begin
				timer1_pin_out <= tog_r[1];
			end
			timer0_pin_oe_n <= ~((mode0 == DTCM_MPWM) |
				(aux_ctrl1_r[`DTCM_BIT_TIMER0_TOGGLE_ENABLE] &
				~mode_sel_r[`DTCM_BIT_CS0])); // RL22
			timer1_pin_oe_n <= ~((mode1 == DTCM_MPWM) |
				(aux_ctrl1_r[`DTCM_BIT_TIMER1_TOGGLE_ENABLE] &
				~mode_sel_r[`DTCM_BIT_CS1])); // RL22
			timer0_irq <= run_ovf_r[`DTCM_BIT_TF0]; // RL26
			timer1_irq <= run_ovf_r[`DTCM_BIT_TF1]; // RL26
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence run_rollover_s;
		tick0 && mode0 == DTCM_M16 && cnt0_r == 16'hffff;
	endsequence

	ovf_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		run_rollover_s |=> run_ovf_r[`DTCM_BIT_TF0]) // RL4
		else $error("rollover did not set flag");
	run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!run_ovf_r[`DTCM_BIT_TR0] && mode0 != DTCM_MSPL && !wr_en)
		|=> $stable(cnt0_r)) // RL5
		else $error("count moved while stopped");
	reload_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick0 && mode0 == DTCM_M8AR && cnt0_r.lo == 8'hff && !wr_en)
		|=> cnt0_r.lo == $past(cnt0_r.hi) && $stable(cnt0_r.hi)) // RL8
		else $error("auto reload wrong");
	t1_mode3_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode1 == DTCM_MSPL && !wr_en) |=> $stable(cnt1_r)) // RL9
		else $error("timer 1 counted in mode 3");
	split_hi_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick0h && cnt0_r.hi == 8'hff && !wr_en)
		|=> run_ovf_r[`DTCM_BIT_TF1]) // RL11
		else $error("split high byte flag missing");
	pwm_force_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode0 == DTCM_MPWM && cnt0_r.hi == 8'hff)[*2]
		|-> !timer0_pin_out) // RL16
		else $error("pwm ffh not low");
	toggle_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
		(aux_ctrl1_r[`DTCM_BIT_TIMER0_TOGGLE_ENABLE] && ovf0 && mode0 != DTCM_MPWM)
		|=> ##1 timer0_pin_out != $past(timer0_pin_out)) // RL20
		else $error("toggle missing");
	irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		run_ovf_r[`DTCM_BIT_TF1] |=> timer1_irq) // RL26
		else $error("irq not following flag");
endmodule

// ===== sim/dtcm_pin_model.sv
// far-side model of the two shared timer pins
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module dtcm_pin_model (
	input  wire logic pclk,
	input  wire logic timer0_pin_out,
	input  wire logic timer1_pin_out,
	input  wire logic timer0_pin_oe_n,
	input  wire logic timer1_pin_oe_n,
	output logic      timer0_pin_in,
	output logic      timer1_pin_in
);
	logic drv0;
	logic drv1;
	initial begin
		drv0 = 1'b0;
		drv1 = 1'b0;
	end
	// the device wins the wire whenever it drives
	assign timer0_pin_in = timer0_pin_oe_n ? drv0 : timer0_pin_out;
	assign timer1_pin_in = timer1_pin_oe_n ? drv1 : timer1_pin_out;
	// each level held three cycles so every level is sampled
	task automatic pulse(input logic which, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge pclk);
			{drv1, drv0} <= {which, ~which};
			repeat (3) @(posedge pclk);
			{drv1, drv0} <= 2'b00;
		end
	endtask
endmodule

// ===== sim/test_dual_timer_counter_modes.sv
// register and pin tests of the dual timer block
`timescale 1ns/1ns
`include "dtcm_params.svh"
////////////////////////////////////////////////////////////////////////////////
module test_dual_timer_counter_modes
	import dtcm_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        t0_in;
	logic        t1_in;
	logic        t0_out;
	logic        t1_out;
	logic        t0_oe_n;
	logic        t1_oe_n;
	logic        ack0;
	logic        ack1;
	logic        irq0;
	logic        irq1;
	int          n_fail;
	int          num_checks;
	int          cyc;
	logic [31:0] q;
	logic        err;
	dtcm_top dtcm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer0_pin_in(t0_in), .timer1_pin_in(t1_in),
		.timer0_pin_out(t0_out), .timer1_pin_out(t1_out),
		.timer0_pin_oe_n(t0_oe_n), .timer1_pin_oe_n(t1_oe_n),
		.timer0_vector_ack(ack0), .timer1_vector_ack(ack1),
		.timer0_irq(irq0), .timer1_irq(irq1));
	dtcm_pin_model dtcm_pin_model_inst (.pclk(pclk), .timer0_pin_out(t0_out),
		.timer1_pin_out(t1_out), .timer0_pin_oe_n(t0_oe_n),
		.timer1_pin_oe_n(t1_oe_n), .timer0_pin_in(t0_in),
		.timer1_pin_in(t1_in));
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// hang guard: all tests fit well under this ceiling
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= 12'(a * `DTCM_WORD_SCALE);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_fail++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd_chk(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask
	// low cycles of the pwm pin over one full period
	task automatic pwm_lows(input logic [7:0] hi, input int exp);
		int lows;
		wr(`DTCM_OFS_COUNT0, {16'h0, hi, 8'h00});
		repeat (300) @(posedge pclk);
		lows = 0;
		repeat (256) begin
			@(posedge pclk);
			lows += (t0_out === 1'b0);
		end
		check("pwm lows", lows, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		num_checks = 0;
		cyc = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ack0 = 1'b0;
		ack1 = 1'b0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("run ovf", `DTCM_OFS_RUN_OVF, 32'h00);
		rd_chk("mode sel", `DTCM_OFS_MODE_SEL, 32'h00);
		rd_chk("aux mode", `DTCM_OFS_AUX_MODE, 32'h00);
		rd_chk("unmapped", 12'h0f0, 32'h0);
		check("slverr", err, 1'b1);
		check("irq idle", irq0 | irq1, 1'b0);
		check("pins idle", {t1_out, t0_out}, 2'b11);
		$display("test reset done");
		// run clear: count must hold
		wr(`DTCM_OFS_MODE_SEL, 32'h01);
		wr(`DTCM_OFS_COUNT0, 32'h1234);
		repeat (20) @(posedge pclk);
		rd_chk("held count", `DTCM_OFS_COUNT0, 32'h1234);
		// mode 1 rollover, flag, irq, vector clear
		wr(`DTCM_OFS_COUNT0, 32'hfffe);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		repeat (6) @(posedge pclk);
		rd_chk("tf0 mode1", `DTCM_OFS_RUN_OVF, 32'h30);
		check("irq0", irq0, 1'b1);
		// stop but keep the flag so that only the vector clears it
		wr(`DTCM_OFS_RUN_OVF, 32'h20);
		ack0 <= 1'b1;
		@(posedge pclk);
		ack0 <= 1'b0;
		repeat (2) @(posedge pclk);
		rd_chk("tf0 acked", `DTCM_OFS_RUN_OVF, 32'h00);
		$display("test mode 1 done");
		// mode 0: 13-bit count, low byte top bits read zero
		wr(`DTCM_OFS_MODE_SEL, 32'h00);
		wr(`DTCM_OFS_COUNT0, 32'hff1e);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		repeat (6) @(posedge pclk);
		rd_chk("tf0 mode0", `DTCM_OFS_RUN_OVF, 32'h30);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		apb(1'b0, `DTCM_OFS_COUNT0, 32'h0);
		check("mode0 lo top", q[7:5], 3'b000);
		// mode 2: reload from high byte, high byte kept
		wr(`DTCM_OFS_MODE_SEL, 32'h02);
		wr(`DTCM_OFS_COUNT0, 32'hf0fe);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		repeat (6) @(posedge pclk);
		rd_chk("tf0 mode2", `DTCM_OFS_RUN_OVF, 32'h30);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		apb(1'b0, `DTCM_OFS_COUNT0, 32'h0);
		check("mode2 hi", q[15:8], 8'hf0);
		check("mode2 reload", q[7:4], 4'hf);
		$display("test modes 0 and 2 done");
		// timer 1 in mode 3 stays stopped although its run bit is set
		wr(`DTCM_OFS_MODE_SEL, 32'h30);
		wr(`DTCM_OFS_COUNT1, 32'h0000);
		wr(`DTCM_OFS_RUN_OVF, 32'h40);
		repeat (20) @(posedge pclk);
		rd_chk("t1 mode3", `DTCM_OFS_COUNT1, 32'h0000);
		// external counting of falling edges on both pins
		wr(`DTCM_OFS_MODE_SEL, 32'h05);
		wr(`DTCM_OFS_COUNT0, 32'h0000);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		check("t0 pin input", t0_oe_n, 1'b1);
		dtcm_pin_model_inst.pulse(1'b0, 3);
		repeat (4) @(posedge pclk);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		rd_chk("ext count", `DTCM_OFS_COUNT0, 32'h0003);
		wr(`DTCM_OFS_MODE_SEL, 32'h50);
		wr(`DTCM_OFS_COUNT1, 32'h0000);
		wr(`DTCM_OFS_RUN_OVF, 32'h40);
		check("t1 pin input", t1_oe_n, 1'b1);
		dtcm_pin_model_inst.pulse(1'b1, 2);
		repeat (4) @(posedge pclk);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		rd_chk("ext count1", `DTCM_OFS_COUNT1, 32'h0002);
		// timer 0 split: high byte runs on the timer 1 run bit and flag
		wr(`DTCM_OFS_MODE_SEL, 32'h03);
		wr(`DTCM_OFS_COUNT0, 32'hff00);
		wr(`DTCM_OFS_COUNT1, 32'h0000);
		wr(`DTCM_OFS_RUN_OVF, 32'h40);
		repeat (4) @(posedge pclk);
		rd_chk("split tf1", `DTCM_OFS_RUN_OVF, 32'hc0);
		apb(1'b0, `DTCM_OFS_COUNT0, 32'h0);
		check("split lo held", q[7:0], 8'h00);
		apb(1'b0, `DTCM_OFS_COUNT1, 32'h0);
		check("t1 runs", q[15:0] != 16'h0000, 1'b1);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		$display("test mode 3 and counter done");
		// timer 1 mode 2 with toggle output and vector clear
		wr(`DTCM_OFS_MODE_SEL, 32'h20);
		wr(`DTCM_OFS_AUX_CTRL1, 32'h02);
		wr(`DTCM_OFS_COUNT1, 32'h00fe);
		check("t1 toggle idle", t1_out, 1'b1);
		wr(`DTCM_OFS_RUN_OVF, 32'h40);
		repeat (8) @(posedge pclk);
		check("t1 toggle inv", t1_out, 1'b0);
		check("t1 drives pin", t1_oe_n, 1'b0);
		check("irq1", irq1, 1'b1);
		rd_chk("tf1 mode2", `DTCM_OFS_RUN_OVF, 32'hc0);
		ack1 <= 1'b1;
		@(posedge pclk);
		ack1 <= 1'b0;
		repeat (2) @(posedge pclk);
		rd_chk("tf1 acked", `DTCM_OFS_RUN_OVF, 32'h40);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		wr(`DTCM_OFS_AUX_CTRL1, 32'h00);
		$display("test timer 1 done");
		// toggle output: high until overflow, then inverted
		wr(`DTCM_OFS_MODE_SEL, 32'h01);
		wr(`DTCM_OFS_AUX_CTRL1, 32'h01);
		repeat (3) @(posedge pclk);
		check("toggle idle", t0_out, 1'b1);
		check("t0 drives pin", t0_oe_n, 1'b0);
		wr(`DTCM_OFS_COUNT0, 32'hfffe);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		repeat (8) @(posedge pclk);
		check("toggle inv", t0_out, 1'b0);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		wr(`DTCM_OFS_AUX_CTRL1, 32'h00);
		$display("test toggle done");
		// pwm duty: forced high, forced low, and a quarter low
		// low bits first so no reserved code is ever formed
		wr(`DTCM_OFS_MODE_SEL, 32'h02);
		wr(`DTCM_OFS_AUX_MODE, 32'h01);
		wr(`DTCM_OFS_RUN_OVF, 32'h10);
		pwm_lows(8'h00, 0);
		pwm_lows(8'hff, 256);
		pwm_lows(8'h40, 64);
		wr(`DTCM_OFS_RUN_OVF, 32'h00);
		$display("test pwm done");
		give_verdict();
	end
endmodule
